/* verilog/xcvr_map.svh */
// offsets, field positions, fixed values and default counts of the status word
// assumes nothing; included by the package and the modules that need it
`ifndef XCVR_MAP_SVH
`define XCVR_MAP_SVH

// status word layout
`define ST_WIDTH 16
`define ST_FLAG_COUNT 11
`define ST_DIRECT_TOP 3
`define ST_LATCH_LOW 4
`define ST_LATCH_HIGH 10
`define ST_ERR_LOW 5
`define ST_RESERVED_HIGH 14
`define ST_RESERVED_LOW 11
`define ST_PARITY 15
`define ST_RESERVED_VALUE 4'hA

// reset values: only the power-on flag is up, parity of that word is odd
`define FLAGS_RESET 11'h010
`define ST_RESET_WORD 16'hD010

// serial readout length in clock cycles
`define SER_BITS 5'h10
`define SER_COUNT_MAX 5'h11

// default filter and clamp durations, device clock cycles
`define TX_CLAMP_CYCLES 1000
`define GUARD_CLAMP_CYCLES 1000
`define UV_DETECT_CYCLES 100
`define UV_RECOVER_CYCLES 100

`endif

/* verilog/xcvr_pkg.sv */
// types shared by the flag and status logic
// assumes xcvr_map.svh is on the include path
package xcvr_pkg;
  `include "xcvr_map.svh"

  // operating modes of the transceiver core
  typedef enum logic [1:0] {
    MODE_POWER_OFF,
    MODE_STANDBY,
    MODE_NORMAL
  } mode_type;

  // flags in status word order, bit 0 first from the right
  typedef struct packed {
    logic serial_err;
    logic io_uv;
    logic core_uv;
    logic tx_clamp;
    logic over_temp;
    logic bus_err;
    logic power_on;
    logic guard_clamp;
    logic tx_enabled;
    logic normal;
    logic wake;
  } flags_type;

  // supply, temperature and bus detections, already on core_clk
  typedef struct packed {
    logic core_above_por;
    logic core_below_detect;
    logic core_above_recovery;
    logic io_below_detect;
    logic io_above_recovery;
    logic over_temp;
    logic bus_error_seen;
    logic bus_wake_seen;
  } monitor_type;
endpackage

/* verilog/pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // sampling clock
  input wire logic srst, // synchronous reset, high
  input wire logic [WIDTH-1:0] pin_in, // raw pin levels
  output logic [WIDTH-1:0] pin_sync_out // levels after two flops
);
  // one pair of flops per pin; the first flop feeds only the second
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1_reg;
    logic stage2_reg;
    always_ff @(posedge clk) begin
      stage1_reg <= srst ? 1'b0 : pin_in[i];
      stage2_reg <= srst ? 1'b0 : stage1_reg;
    end
    assign pin_sync_out[i] = stage2_reg;
  end
endmodule

/* verilog/hold_timer.sv */
// reports a condition that has been true for more than HOLD cycles
// assumes cond is on clk; any false cycle restarts the count
`timescale 1ns/1ps
module hold_timer #(
  parameter int HOLD = 16
) (
  input wire logic clk, // core clock
  input wire logic srst, // synchronous reset, high
  input wire logic cond, // condition being timed
  output logic held // high once cond outlasted HOLD
);
  localparam logic [19:0] HOLD_W = 20'(HOLD);
  logic [19:0] count_reg;
  logic [19:0] count_next;

  // count saturates so a long hold does not wrap back to idle
  assign count_next = !cond ? 20'h00000 :
                      (count_reg > HOLD_W) ? count_reg : count_reg + 20'h00001;

  always_ff @(posedge clk) begin
    count_reg <= srst ? 20'h00000 : count_next;
    held <= srst ? 1'b0 : (cond && count_reg >= HOLD_W);
  end
endmodule

/* verilog/xcvr_flags.sv */
// flag logic, latched status word and serial status readout
// assumes monitor inputs are on core_clk and pins are asynchronous
`timescale 1ns/1ps
`include "xcvr_map.svh"

// Operation
// RULE1: wake flag set on bus wake in Standby without core undervoltage; cleared entering Normal.
// RULE2: normal flag tracks being in Normal mode.
// RULE3: transmitter on only with guardian high, Normal, no overtemp, no clamp.
// RULE4: guardian clamp flag set after long high guardian input; cleared when low.
// RULE5: power-on flag set on supply recovery, cleared entering Normal.
// RULE6: bus error flag follows detection, cleared by transmit enable rising edge; the code clears it when the detection ends, with no edge used.
// RULE7: overtemp flag set when hot; cleared by transmit enable high when cool.
// RULE8: transmit clamp flag set after long low transmit enable; cleared when high.
// RULE9: supply undervoltage flags filtered both ways; force Standby and error low.
// RULE10: wrong count of serial clock falls sets serial error; select fall clears.
// RULE11: reset clears every flag except the power-on flag.
// RULE12: four Normal-only flags change only in Normal mode or when leaving.
// RULE13: sixteen-bit status word, flags low, parity top, read in serial mode.
// RULE14: flags map to bits zero to ten in fixed order.
// RULE15: reserved bits eleven to fourteen read low, high, low, high.
// RULE16: bits zero to three follow flags; four to ten latch until read.
// RULE17: latched bits clear in Power-off mode.
// RULE18: parity bit set when the status bits have odd parity.
// RULE19: eleven distinct flags, each visible in the readout.
// RULE20: select low starts readout; data driven low, shifted on clock rise.
// RULE21: exactly sixteen clocks then select high completes a readout.
// RULE22: serial mode error indicator low while any error bit is set; the code uses the latched error bits only with the standby select pin high.
// RULE23: simple error mode neither latches errors nor offers a readout.
// RULE24: word is shifted most significant bit first, parity leading.
// RULE25: detections arrive synchronised; durations are cycle parameters.
module xcvr_flags
  import xcvr_pkg::*;
#(
  parameter int TX_CLAMP_CYCLES = `TX_CLAMP_CYCLES,
  parameter int GUARD_CLAMP_CYCLES = `GUARD_CLAMP_CYCLES,
  parameter int UV_DETECT_CYCLES = `UV_DETECT_CYCLES,
  parameter int UV_RECOVER_CYCLES = `UV_RECOVER_CYCLES
) (
  input wire logic core_clk, // device clock, 125 MHz
  input wire logic srst, // power-on reset, synchronous, high
  input wire logic transmit_enable_low, // transmit enable pin, low active
  input wire logic bus_guardian_enable, // guardian enable pin
  input wire logic standby_select_low, // standby select pin, low means standby
  input wire logic serial_select_low, // serial select pin, low active
  input wire logic serial_clk, // serial clock pin from host
  input wire logic simple_error_mode, // high selects simple error indication
  input wire xcvr_pkg::monitor_type monitor, // synchronised analog detections
  output logic error_indicator_low, // error indicator pin, low active
  output logic rx_force_low, // holds receive data low
  output logic transmitter_on, // enables the bus transmitter
  output logic serial_data_out, // serial data pin level
  output logic serial_data_out_oe, // serial data pin driven when high
  output xcvr_pkg::mode_type mode, // current operating mode
  output logic [`ST_WIDTH-1:0] status_word // status word as it would shift
);
  import xcvr_pkg::*;

  // pins cross into core_clk through two flops each
  // select enters inverted, so the flushed sync level equals the idle pin
  logic [4:0] pins_sync;
  logic transmit_enable_low_low_s;
  logic bge_s;
  logic standby_select_low_s;
  logic sel_on_s;
  logic sclk_s;
  pin_sync #(.WIDTH(5)) u_sync (
    .clk(core_clk),
    .srst(srst),
    .pin_in({transmit_enable_low, bus_guardian_enable, standby_select_low,
             !serial_select_low, serial_clk}),
    .pin_sync_out(pins_sync)
  );
  assign {transmit_enable_low_low_s, bge_s, standby_select_low_s, sel_on_s, sclk_s} = pins_sync;

  // delayed copies for edge detection, taken after the synchroniser
  logic transmit_enable_low_low_d_reg;
  logic sel_on_d_reg;
  logic sclk_d_reg;
  always_ff @(posedge core_clk) begin
    transmit_enable_low_low_d_reg <= srst ? 1'b1 : transmit_enable_low_low_s;
    sel_on_d_reg <= srst ? 1'b0 : sel_on_s;
    sclk_d_reg <= srst ? 1'b0 : sclk_s;
  end
  wire transmit_enable_low_rise = transmit_enable_low_low_s && !transmit_enable_low_low_d_reg;
  wire sel_fall = sel_on_s && !sel_on_d_reg;
  wire sel_rise = !sel_on_s && sel_on_d_reg;
  wire sclk_rise = sclk_s && !sclk_d_reg;
  wire sclk_fall = !sclk_s && sclk_d_reg;

  // duration filters, all counted in core_clk cycles
  logic tx_low_held;
  logic bge_high_held;
  logic core_uv_det;
  logic core_uv_rec;
  logic io_uv_det;
  logic io_uv_rec;
  hold_timer #(.HOLD(TX_CLAMP_CYCLES)) u_tx_clamp ( // RULE25
    .clk(core_clk), .srst(srst), .cond(!transmit_enable_low_low_s), .held(tx_low_held));
  hold_timer #(.HOLD(GUARD_CLAMP_CYCLES)) u_guard_clamp (
    .clk(core_clk), .srst(srst), .cond(bge_s), .held(bge_high_held));
  hold_timer #(.HOLD(UV_DETECT_CYCLES)) u_core_det (
    .clk(core_clk), .srst(srst), .cond(monitor.core_below_detect), .held(core_uv_det));
  hold_timer #(.HOLD(UV_RECOVER_CYCLES)) u_core_rec (
    .clk(core_clk), .srst(srst), .cond(monitor.core_above_recovery), .held(core_uv_rec));
  hold_timer #(.HOLD(UV_DETECT_CYCLES)) u_io_det (
    .clk(core_clk), .srst(srst), .cond(monitor.io_below_detect), .held(io_uv_det));
  hold_timer #(.HOLD(UV_RECOVER_CYCLES)) u_io_rec (
    .clk(core_clk), .srst(srst), .cond(monitor.io_above_recovery), .held(io_uv_rec));

  // mode selection; undervoltage keeps the core out of Normal
  mode_type mode_reg;
  mode_type mode_next;
  flags_type flags_reg;
  flags_type flags_next;
  assign mode_next = !monitor.core_above_por ? MODE_POWER_OFF :
                     (mode_reg == MODE_POWER_OFF) ? MODE_STANDBY : // RULE5
                     (flags_reg.core_uv || flags_reg.io_uv) ? MODE_STANDBY : // RULE9
                     standby_select_low_s ? MODE_NORMAL : MODE_STANDBY;
  wire in_normal = (mode_reg == MODE_NORMAL);
  wire enter_normal = (mode_next == MODE_NORMAL) && !in_normal;
  wire leave_off = (mode_reg == MODE_POWER_OFF) && (mode_next != MODE_POWER_OFF);
  wire power_off = (mode_reg == MODE_POWER_OFF);

  // serial readout bookkeeping
  logic [4:0] fall_count_reg;
  logic [4:0] fall_count_next;
  logic [`ST_WIDTH-1:0] shift_reg;
  logic [`ST_WIDTH-1:0] shift_next;
  logic sdo_next;
  logic sdo_oe_next;
  wire spi_ok = !simple_error_mode && !power_off && !flags_reg.io_uv; // RULE23
  wire count_high = sel_on_s && sclk_fall && (fall_count_reg >= `SER_BITS);
  wire count_short = sel_rise && (fall_count_reg != `SER_BITS);
  wire read_ok = sel_rise && spi_ok && (fall_count_reg == `SER_BITS) && !flags_reg.serial_err; // RULE21
  wire serial_fault = spi_ok && (count_high || count_short); // RULE10

  // flag next values; the four Normal-only flags hold outside Normal
  always_comb begin
    flags_next = flags_reg;
    flags_next.normal = (mode_next == MODE_NORMAL); // RULE2
    if (mode_reg == MODE_STANDBY && monitor.bus_wake_seen && !flags_reg.core_uv) begin
      flags_next.wake = 1'b1; // RULE1
    end else if (enter_normal) begin
      flags_next.wake = 1'b0; // RULE1
    end
    flags_next.tx_enabled = bge_s && flags_reg.normal && !flags_reg.over_temp
                            && !flags_reg.tx_clamp; // RULE3
    if (leave_off) begin
      flags_next.power_on = 1'b1; // RULE5
    end else if (enter_normal) begin
      flags_next.power_on = 1'b0; // RULE5
    end
    if (in_normal) begin // RULE12
      flags_next.guard_clamp = bge_high_held ? 1'b1 : bge_s && flags_reg.guard_clamp; // RULE4
      // the flag follows the detection alone; the transmit enable edge plays no part
      flags_next.bus_err = monitor.bus_error_seen; // RULE6
      if (monitor.over_temp) begin
        flags_next.over_temp = 1'b1; // RULE7
      end else if (transmit_enable_low_low_s == 1'b0 && !transmit_enable_low_rise) begin
        flags_next.over_temp = flags_reg.over_temp; // cool but transmit enable low
      end else begin
        flags_next.over_temp = 1'b0; // RULE7
      end
      flags_next.tx_clamp = tx_low_held ? 1'b1 : !transmit_enable_low_low_s && flags_reg.tx_clamp; // RULE8
    end
    if (core_uv_det) begin
      flags_next.core_uv = 1'b1; // RULE9
    end else if (core_uv_rec) begin
      flags_next.core_uv = 1'b0; // RULE9
    end
    if (io_uv_det) begin
      flags_next.io_uv = 1'b1; // RULE9
    end else if (io_uv_rec) begin
      flags_next.io_uv = 1'b0; // RULE9
    end
    // a fault wins over a select fall in the same cycle
    if (serial_fault) begin
      flags_next.serial_err = 1'b1; // RULE10
    end else if (sel_fall) begin
      flags_next.serial_err = 1'b0; // RULE10
    end
  end

  // reset clears every flag, but the power-on flag is set, not cleared
  always_ff @(posedge core_clk) begin
    mode_reg <= srst ? MODE_POWER_OFF : mode_next;
    flags_reg <= srst ? flags_type'(`FLAGS_RESET) : flags_next; // RULE11
  end

  // status bits: low four direct, upper seven latched until a good read
  logic [`ST_LATCH_HIGH:0] bits_reg;
  logic [`ST_LATCH_HIGH:0] bits_next;
  wire [`ST_LATCH_HIGH:0] flag_vec = flags_next; // RULE14 RULE19
  assign bits_next[`ST_DIRECT_TOP:0] = flag_vec[`ST_DIRECT_TOP:0]; // RULE16
  genvar b;
  for (b = `ST_LATCH_LOW; b <= `ST_LATCH_HIGH; b++) begin : g_latch
    // simple mode passes the flag straight; power-off empties the latch
    assign bits_next[b] = simple_error_mode ? flag_vec[b] : // RULE23
                          (mode_next == MODE_POWER_OFF) ? 1'b0 : // RULE17
                          flag_vec[b] || (bits_reg[b] && !read_ok); // RULE16
  end
  wire [14:0] low_word = {`ST_RESERVED_VALUE, bits_next}; // RULE15
  wire [`ST_WIDTH-1:0] word_next = {^low_word, low_word}; // RULE13 RULE18

  // readout shifter, most significant bit leaves first
  always_comb begin
    shift_next = shift_reg;
    fall_count_next = fall_count_reg;
    sdo_next = serial_data_out;
    sdo_oe_next = serial_data_out_oe;
    if (!spi_ok || !sel_on_s || sel_rise) begin
      sdo_oe_next = 1'b0; // RULE20
      sdo_next = 1'b0;
      fall_count_next = 5'h00;
    end else if (sel_fall) begin
      shift_next = status_word; // RULE20
      sdo_next = 1'b0;
      sdo_oe_next = 1'b1;
      fall_count_next = 5'h00;
    end else begin
      if (sclk_rise) begin
        sdo_next = shift_reg[`ST_WIDTH-1]; // RULE24
        shift_next = {shift_reg[`ST_WIDTH-2:0], 1'b0};
      end
      if (sclk_fall && fall_count_reg != `SER_COUNT_MAX) begin
        fall_count_next = fall_count_reg + 5'h01;
      end
      if (count_high || flags_reg.serial_err) begin
        sdo_oe_next = 1'b0; // RULE10
      end
    end
  end

  // error indicator sources; latched bits stand in for errors in serial mode
  wire err_bits = |bits_next[`ST_LATCH_HIGH:`ST_ERR_LOW];
  wire simple_errs = flags_next.bus_err || flags_next.over_temp || flags_next.tx_clamp;
  wire err_low_next = (flags_next.wake && !standby_select_low_s) || // RULE1
                      flags_next.core_uv || flags_next.io_uv || // RULE9
                      (standby_select_low_s && (simple_error_mode ? simple_errs : err_bits)); // RULE22

  // every output straight from a flop
  always_ff @(posedge core_clk) begin
    bits_reg <= srst ? `FLAGS_RESET : bits_next;
    status_word <= srst ? `ST_RESET_WORD : word_next;
    shift_reg <= srst ? 16'h0000 : shift_next;
    fall_count_reg <= srst ? 5'h00 : fall_count_next;
    serial_data_out <= srst ? 1'b0 : sdo_next;
    serial_data_out_oe <= srst ? 1'b0 : sdo_oe_next;
    error_indicator_low <= srst ? 1'b1 : !err_low_next;
    rx_force_low <= srst ? 1'b0 : flags_next.wake; // RULE1
    transmitter_on <= srst ? 1'b0 : flags_next.tx_enabled; // RULE3
    mode <= srst ? MODE_POWER_OFF : mode_next;
  end

  // checks on the flag and readout behaviour
  property p_tx_gate;
    @(posedge core_clk) disable iff (srst)
    transmitter_on |-> $past(bge_s) && !$past(flags_reg.over_temp) && !$past(flags_reg.tx_clamp);
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmitter on without its enables"); // RULE3

  property p_wake_clear;
    @(posedge core_clk) disable iff (srst)
    enter_normal |=> !flags_reg.wake ##1 !rx_force_low;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake flag kept in Normal"); // RULE1

  property p_normal_flag;
    @(posedge core_clk) disable iff (srst)
    flags_reg.normal == in_normal;
  endproperty
  a_normal_flag: assert property (p_normal_flag) else $error("normal flag disagrees"); // RULE2

  property p_guard_hold;
    @(posedge core_clk) disable iff (srst)
    !in_normal |=> $stable(flags_reg.guard_clamp) && $stable(flags_reg.bus_err);
  endproperty
  a_guard_hold: assert property (p_guard_hold) else $error("flag moved outside Normal"); // RULE12

  property p_parity;
    @(posedge core_clk) disable iff (srst)
    ##1 (^status_word) == 1'b0;
  endproperty
  a_parity: assert property (p_parity) else $error("status word parity wrong"); // RULE18

  property p_reserved;
    @(posedge core_clk) disable iff (srst)
    ##1 status_word[`ST_RESERVED_HIGH:`ST_RESERVED_LOW] == `ST_RESERVED_VALUE;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits wrong"); // RULE15

  property p_too_many;
    @(posedge core_clk) disable iff (srst)
    spi_ok && count_high && !sel_rise |=> flags_reg.serial_err && !serial_data_out_oe;
  endproperty
  a_too_many: assert property (p_too_many) else $error("extra clock not flagged"); // RULE10

  property p_latch_hold;
    @(posedge core_clk) disable iff (srst)
    !simple_error_mode && bits_reg[`ST_ERR_LOW] && !read_ok && mode_next != MODE_POWER_OFF
    |=> bits_reg[`ST_ERR_LOW];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost early"); // RULE16

  property p_uv_err;
    @(posedge core_clk) disable iff (srst)
    flags_reg.core_uv |-> error_indicator_low == 1'b0 ##1 mode_reg != MODE_NORMAL;
  endproperty
  a_uv_err: assert property (p_uv_err) else $error("undervoltage not shown"); // RULE9

  property p_read_done;
    @(posedge core_clk) disable iff (srst)
    read_ok |=> !serial_data_out_oe;
  endproperty
  a_read_done: assert property (p_read_done) else $error("data out still driven"); // RULE21

  property p_off_clear;
    @(posedge core_clk) disable iff (srst)
    mode_next == MODE_POWER_OFF && !simple_error_mode
    |=> bits_reg[`ST_LATCH_HIGH:`ST_LATCH_LOW] == 7'h00;
  endproperty
  a_off_clear: assert property (p_off_clear) else $error("latched bits kept in power-off"); // RULE17

  property p_sel_clear;
    @(posedge core_clk) disable iff (srst)
    sel_fall && !serial_fault |=> !flags_reg.serial_err;
  endproperty
  a_sel_clear: assert property (p_sel_clear) else $error("serial error kept past select"); // RULE10

  property p_oe_idle;
    @(posedge core_clk) disable iff (srst)
    !sel_on_s |=> !serial_data_out_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data out driven while deselected"); // RULE20

  property p_sdo_start;
    @(posedge core_clk) disable iff (srst)
    sel_fall && spi_ok |=> serial_data_out_oe && !serial_data_out;
  endproperty
  a_sdo_start: assert property (p_sdo_start) else $error("data out not low at start"); // RULE20

  property p_clamp_off;
    @(posedge core_clk) disable iff (srst)
    flags_reg.tx_clamp |=> !transmitter_on;
  endproperty
  a_clamp_off: assert property (p_clamp_off) else $error("transmitter on while clamped"); // RULE8
endmodule

/* dv/spi_host_model.sv */
// host side of the serial status readout: drives select and clock, samples data
// assumes core_clk paces the pins; data pin already resolved by the bench
`timescale 1ns/1ps
module spi_host_model (
  input wire logic core_clk, // device clock, paces pin changes
  input wire logic sdo_pin, // resolved serial data pin level
  output logic serial_select_low, // select to device, low active
  output logic serial_clk // serial clock, stands low outside frames
);
  initial begin
    serial_select_low = 1'b1;
    serial_clk = 1'b0;
  end

  // half of an 80 ns serial period, changes land just after a core edge
  task automatic half();
    repeat (5) @(posedge core_clk);
    #1;
  endtask

  // one frame of n clocks; data sampled before each fall, msb arrives first
  task automatic read_frame(input int n, output logic [15:0] word);
    word = 16'h0000;
    serial_select_low = 1'b0;
    half();
    for (int k = 0; k < n; k++) begin
      serial_clk = 1'b1;
      half();
      word = {word[14:0], sdo_pin};
      serial_clk = 1'b0;
      half();
    end
    serial_select_low = 1'b1;
    half();
  endtask
endmodule

/* dv/tb_transceiver_flag_status_register.sv */
// self-checking bench for the flag logic, latched status word and readout
// assumes the package, map header and design modules are compiled first
`timescale 1ns/1ps
`include "xcvr_map.svh"
module tb_transceiver_flag_status_register;
  import xcvr_pkg::*;
  logic core_clk, srst, transmit_enable_low, bus_guardian_enable, standby_select_low;
  logic serial_select_low, serial_clk, simple_error_mode, sdo_pin, oe_seen;
  logic error_indicator_low, rx_force_low, transmitter_on, serial_data_out;
  logic serial_data_out_oe;
  logic [15:0] status_word, rd;
  monitor_type monitor;
  mode_type mode;
  int bad_count = 0;
  int n_checks = 0;

  // short counts keep every filter within a few dozen cycles
  xcvr_flags #(.TX_CLAMP_CYCLES(8), .GUARD_CLAMP_CYCLES(8), .UV_DETECT_CYCLES(8),
    .UV_RECOVER_CYCLES(8)) i_dut (.core_clk(core_clk), .srst(srst),
    .transmit_enable_low(transmit_enable_low), .bus_guardian_enable(bus_guardian_enable),
    .standby_select_low(standby_select_low), .serial_select_low(serial_select_low),
    .serial_clk(serial_clk), .simple_error_mode(simple_error_mode), .monitor(monitor),
    .error_indicator_low(error_indicator_low), .rx_force_low(rx_force_low),
    .transmitter_on(transmitter_on), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .mode(mode), .status_word(status_word));

  spi_host_model i_host (.core_clk(core_clk), .sdo_pin(sdo_pin),
    .serial_select_low(serial_select_low), .serial_clk(serial_clk));

  // released pin shows the inverse so a stale bit never reads as good
  assign sdo_pin = serial_data_out_oe ? serial_data_out : ~serial_data_out;

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // remembers whether the data pin was ever driven
  always @(posedge core_clk) oe_seen <= oe_seen | (serial_data_out_oe === 1'b1);

  function automatic logic [15:0] exp_word(input logic [10:0] b);
    logic [14:0] w;
    w = {`ST_RESERVED_VALUE, b};
    return {^w, w};
  endfunction

  task automatic summarize();
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // bounded wait for the word to settle, then compare
  task automatic expect_word(input logic [15:0] exp);
    int i;
    i = 0;
    while (i < 64 && status_word !== exp) begin
      cyc(1);
      i++;
    end
    chk_word(status_word, exp);
  endtask

  task automatic rd_chk(input logic [15:0] exp);
    i_host.read_frame(16, rd);
    chk_word(rd, exp);
  endtask

  task automatic t_reset();
    srst = 1'b1;
    cyc(19);
    chk_word(status_word, exp_word(11'h010));
    chk_word({14'h0000, mode}, {14'h0000, MODE_POWER_OFF});
    chk_bit(error_indicator_low, 1'b1);
    chk_bit(serial_data_out_oe, 1'b0);
    chk_bit(transmitter_on | rx_force_low, 1'b0);
    cyc(1);
    srst = 1'b0;
    expect_word(exp_word(11'h012));
    chk_word({14'h0000, mode}, {14'h0000, MODE_NORMAL});
    rd_chk(exp_word(11'h012));
    expect_word(exp_word(11'h002));
    chk_bit(serial_data_out_oe, 1'b0);
  endtask

  // bus error or overtemperature: latched until read once the flag clears
  task automatic t_err(input logic temp);
    logic [10:0] b;
    b = temp ? 11'h042 : 11'h022;
    monitor.bus_error_seen = !temp;
    monitor.over_temp = temp;
    expect_word(exp_word(b));
    chk_bit(error_indicator_low, 1'b0);
    monitor.bus_error_seen = 1'b0;
    monitor.over_temp = 1'b0;
    cyc(10);
    chk_word(status_word, exp_word(b));
    rd_chk(exp_word(b));
    expect_word(exp_word(11'h002));
    chk_bit(error_indicator_low, 1'b1);
  endtask

  task automatic t_guard_tx();
    bus_guardian_enable = 1'b1;
    expect_word(exp_word(11'h00E));
    chk_bit(transmitter_on, 1'b1);
    transmit_enable_low = 1'b0;
    expect_word(exp_word(11'h08A));
    chk_bit(transmitter_on, 1'b0);
    chk_bit(error_indicator_low, 1'b0);
    transmit_enable_low = 1'b1;
    bus_guardian_enable = 1'b0;
    expect_word(exp_word(11'h082));
    rd_chk(exp_word(11'h082));
    expect_word(exp_word(11'h002));
  endtask

  // too few and too many clocks within one select period
  task automatic t_serial_err(input int n);
    i_host.read_frame(n, rd);
    expect_word(exp_word(11'h402));
    chk_bit(error_indicator_low, 1'b0);
    chk_bit(serial_data_out_oe, 1'b0);
    rd_chk(exp_word(11'h402));
    expect_word(exp_word(11'h002));
  endtask

  // undervoltage forces standby; readout refused only for the io supply
  task automatic t_uv(input logic io);
    logic [10:0] b;
    b = io ? 11'h200 : 11'h100;
    monitor.io_below_detect = io;
    monitor.io_above_recovery = !io;
    monitor.core_below_detect = !io;
    monitor.core_above_recovery = io;
    expect_word(exp_word(b));
    chk_word({14'h0000, mode}, {14'h0000, MODE_STANDBY});
    chk_bit(error_indicator_low, 1'b0);
    oe_seen = 1'b0;
    i_host.read_frame(16, rd);
    chk_bit(oe_seen, !io);
    monitor = 8'hA8;
    expect_word(exp_word(b | 11'h002));
    rd_chk(exp_word(b | 11'h002));
    expect_word(exp_word(11'h002));
  endtask

  task automatic t_wake();
    standby_select_low = 1'b0;
    expect_word(exp_word(11'h000));
    monitor.over_temp = 1'b1;
    monitor.bus_wake_seen = 1'b1;
    cyc(4);
    monitor.bus_wake_seen = 1'b0;
    expect_word(exp_word(11'h001));
    cyc(20);
    chk_word(status_word, exp_word(11'h001));
    chk_bit(rx_force_low, 1'b1);
    chk_bit(error_indicator_low, 1'b0);
    monitor.over_temp = 1'b0;
    standby_select_low = 1'b1;
    expect_word(exp_word(11'h002));
    chk_bit(rx_force_low, 1'b0);
  endtask

  task automatic t_simple();
    simple_error_mode = 1'b1;
    oe_seen = 1'b0;
    i_host.read_frame(16, rd);
    chk_bit(oe_seen, 1'b0);
    monitor.bus_error_seen = 1'b1;
    cyc(6);
    chk_bit(error_indicator_low, 1'b0);
    monitor.bus_error_seen = 1'b0;
    cyc(6);
    chk_bit(error_indicator_low, 1'b1);
    expect_word(exp_word(11'h002));
    simple_error_mode = 1'b0;
  endtask

  task automatic t_power_off();
    monitor.bus_error_seen = 1'b1;
    cyc(4);
    monitor.bus_error_seen = 1'b0;
    expect_word(exp_word(11'h022));
    monitor.core_above_por = 1'b0;
    expect_word(exp_word(11'h000));
    chk_word({14'h0000, mode}, {14'h0000, MODE_POWER_OFF});
    monitor.core_above_por = 1'b1;
    expect_word(exp_word(11'h012));
    rd_chk(exp_word(11'h012));
    expect_word(exp_word(11'h002));
  endtask

  // a hang ends the run through the same verdict
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    summarize();
  end

  initial begin
    srst = 1'b1;
    transmit_enable_low = 1'b1;
    bus_guardian_enable = 1'b0;
    standby_select_low = 1'b1;
    simple_error_mode = 1'b0;
    oe_seen = 1'b0;
    monitor = 8'hA8;
    @(posedge core_clk);
    #1;
    t_reset();
    t_err(1'b0);
    t_err(1'b1);
    t_guard_tx();
    t_serial_err(15);
    t_serial_err(17);
    t_uv(1'b1);
    t_uv(1'b0);
    t_wake();
    t_simple();
    t_power_off();
    summarize();
  end
endmodule
